// ==== logic/supv_pkg.sv ====
// constants and types shared by the supply supervisor event logic
// assumes a 100 MHz system clock; the comparators themselves sit outside
package supv_pkg;
    // clock period in ps
    localparam int CLK_PERIOD_PS = 10000;
    // settling mask in fast mode, in ns
    localparam int FAST_MASK_NS = 2000;
    // settling mask in normal mode, in ns
    localparam int NORMAL_MASK_NS = 150000;
    localparam int FAST_MASK_CYC = (FAST_MASK_NS * 1000) / CLK_PERIOD_PS;
    localparam int NORMAL_MASK_CYC = (NORMAL_MASK_NS * 1000) / CLK_PERIOD_PS;
    localparam int CNT_W = 16;
    localparam int NUM_SUP = 2;
    localparam int HIGH_IDX = 0;
    localparam int LOW_IDX = 1;

    // register indices on the plain register port
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_MASK = 4'h2;
    localparam logic [3:0] REG_STATE = 4'h3;

    // control field positions, per supervisor byte (high: 0, low: 8)
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_RESET_EN = 1;
    localparam int CTRL_KEEP = 2;
    localparam int CTRL_FAST = 3;
    localparam int CTRL_STRIDE = 8;
    // enabled, reset on event, normal mode, no keep
    localparam logic [7:0] CTRL_RESET_VAL = 8'h03;

    // power modes seen by the supervisors
    typedef enum logic [1:0] {
        PM_ACTIVE,
        PM_LIGHT,
        PM_DEEP
    } power_mode_e;
endpackage : supv_pkg

// ==== logic/supv_if.sv ====
// bundle between the top and one supervisor channel
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface supv_if;
    logic enable;
    logic fast;
    logic keep;
    logic deep_lpm;
    logic restart;
    logic cmp_event;
    logic running;
    logic masking;
    logic event_hit;
    modport top (output enable, fast, keep, deep_lpm, restart, cmp_event,
                 input running, masking, event_hit);
    modport chan (input enable, fast, keep, deep_lpm, restart, cmp_event,
                  output running, masking, event_hit);
endinterface : supv_if
`default_nettype wire

// ==== logic/supv_channel.sv ====
// one supervisor channel: power gating and settling mask
// assumes cmp_event is already synchronised to clk_sys
`timescale 1ns/1ps
`default_nettype none
module supv_channel (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // link to the top
    supv_if.chan sif
);
    logic [supv_pkg::CNT_W-1:0] mask_cnt_q;
    logic [supv_pkg::CNT_W-1:0] mask_cnt_d;
    logic running_q;
    wire running_d;
    wire turn_on;
    wire [supv_pkg::CNT_W-1:0] mask_len;

    // off in deep modes unless kept running
    assign running_d = sif.enable & (sif.keep | ~sif.deep_lpm);
    assign turn_on = (running_d & ~running_q) | sif.restart;
    // mask length follows the mode at the moment of turn-on
    assign mask_len = sif.fast ?
        supv_pkg::CNT_W'(supv_pkg::FAST_MASK_CYC) :
        supv_pkg::CNT_W'(supv_pkg::NORMAL_MASK_CYC);
    always_comb
    begin
        mask_cnt_d = mask_cnt_q;
        if (turn_on & running_d)
            mask_cnt_d = mask_len;
        else if (~running_d)
            mask_cnt_d = '0;
        else if (mask_cnt_q != '0)
            mask_cnt_d = mask_cnt_q - 1'b1;
    end

    // reset clears the count; the mask starts on the first edge after it, since the comparators wake up enabled
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            running_q <= 1'b0;
            mask_cnt_q <= '0;
        end
        else
        begin
            running_q <= running_d;
            mask_cnt_q <= mask_cnt_d;
        end
    end

    assign sif.running = running_q;
    assign sif.masking = mask_cnt_q != '0;
    assign sif.event_hit = running_q & (mask_cnt_q == '0) & sif.cmp_event;

    a_mask_blocks_hit: assert property (@(posedge clk_sys) disable iff (rst)
        (mask_cnt_q != '0) |-> !sif.event_hit)
        else $error("event passed during settling mask");
    a_deep_off: assert property (@(posedge clk_sys) disable iff (rst)
        (sif.deep_lpm && !sif.keep) |=> !running_q)
        else $error("comparator still on in deep mode");
    a_keep_on: assert property (@(posedge clk_sys) disable iff (rst)
        (sif.enable && sif.keep) |=> running_q)
        else $error("kept comparator switched off");
    a_fast_len: assert property (@(posedge clk_sys) disable iff (rst)
        (turn_on && running_d && sif.fast) |=>
        mask_cnt_q == supv_pkg::CNT_W'(supv_pkg::FAST_MASK_CYC))
        else $error("fast mask length wrong");
    a_normal_len: assert property (@(posedge clk_sys) disable iff (rst)
        (turn_on && running_d && !sif.fast) |=>
        mask_cnt_q == supv_pkg::CNT_W'(supv_pkg::NORMAL_MASK_CYC))
        else $error("normal mask length wrong");
endmodule : supv_channel
`default_nettype wire

// ==== logic/supv_event_mask.sv ====
// supply supervisor event masking, flags, reset request and pin float
// assumes comparator outputs are asynchronous pins; register port is local
`timescale 1ns/1ps
`default_nettype none
// Contract
// - fast mode masks events for 2 us
// - mask length depends on selected mode
// - unmasked event sets flag, optional reset
// - pins float on a hit and while a set flag's channel is masking
// - keep clear: comparators off in deep modes
// - keep set: comparators run in deep modes
// - reset or clear re-enables both supervisors
// - two independent high and low channels
module supv_event_mask (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // system side
    input wire logic soft_power_up_clear,
    input wire logic deep_low_power_modes,
    input wire logic [1:0] cmp_raw,
    output logic por_request,
    output logic pins_float,
    output logic irq
);
    logic [1:0] cmp_s1_q;
    logic [1:0] cmp_s2_q;
    logic [7:0] ctrl_q [supv_pkg::NUM_SUP];
    logic [1:0] supervisor_event_flag_q;
    logic [1:0] irq_mask_q;
    logic por_q;
    logic float_q;
    logic irq_q;
    logic restart_q;
    logic [31:0] rdata_q;
    wire [1:0] hit;
    wire [1:0] masking;
    wire [1:0] running;
    wire status_rd;
    wire [1:0] flag_d;
    wire [31:0] rdata_d;
    wire irq_d;

    function automatic logic sel(input logic [3:0] a, input logic [3:0] r);
        sel = (a == r);
    endfunction : sel

    // comparator pins are asynchronous: two stages before use
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cmp_s1_q <= 2'h0;
            cmp_s2_q <= 2'h0;
        end
        else
        begin
            cmp_s1_q <= cmp_raw;
            cmp_s2_q <= cmp_s1_q;
        end
    end

    genvar g;
    generate
        for (g = 0; g < supv_pkg::NUM_SUP; g++)
        begin : g_chan
            supv_if sif();
            // per-channel control byte; soft clear forces enable back on
            always_ff @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                    ctrl_q[g] <= supv_pkg::CTRL_RESET_VAL;
                else if (soft_power_up_clear)
                    ctrl_q[g][supv_pkg::CTRL_ENABLE] <= 1'b1;
                else if (reg_wr & sel(reg_addr, supv_pkg::REG_CTRL))
                    ctrl_q[g] <= reg_wdata[g*supv_pkg::CTRL_STRIDE +: 8];
            end
            assign sif.enable = ctrl_q[g][supv_pkg::CTRL_ENABLE];
            assign sif.fast = ctrl_q[g][supv_pkg::CTRL_FAST];
            assign sif.keep = ctrl_q[g][supv_pkg::CTRL_KEEP];
            assign sif.deep_lpm = deep_low_power_modes;
            assign sif.restart = restart_q;
            assign sif.cmp_event = cmp_s2_q[g];
            assign hit[g] = sif.event_hit;
            assign masking[g] = sif.masking;
            assign running[g] = sif.running;
            supv_channel u_chan (
                .clk_sys(clk_sys),
                .rst(rst),
                .sif(sif.chan)
            );
        end
    endgenerate

    // reading status clears it, but a new hit in that cycle wins
    assign status_rd = reg_rd & sel(reg_addr, supv_pkg::REG_STATUS);
    assign flag_d = hit | (supervisor_event_flag_q & {2{~status_rd}});
    // interrupt level follows the next flag value, so it changes in step with the flags
    assign irq_d = |(flag_d & irq_mask_q);
    // register map seen by software:
    //   index 0: control, low byte high side, next byte low side
    //            per byte: enable, reset enable, lowpower keep, fast mode
    //   index 1: status flags, bit 0 high side, bit 1 low side
    //            a read clears them, a hit in the read cycle survives
    //   index 2: interrupt mask of the same layout as the status flags
    //   index 3: channel state, running in bits 1:0, masking in bits 3:2
    //   any other index reads as zero and ignores writes
    // read data stand for exactly one cycle and are zero otherwise, so a
    // master that samples late sees zero rather than stale data
    assign rdata_d =
        sel(reg_addr, supv_pkg::REG_CTRL) ?
            {16'h0000, ctrl_q[supv_pkg::LOW_IDX],
             ctrl_q[supv_pkg::HIGH_IDX]} :
        sel(reg_addr, supv_pkg::REG_STATUS) ?
            {30'h0, supervisor_event_flag_q} :
        sel(reg_addr, supv_pkg::REG_MASK) ? {30'h0, irq_mask_q} :
        sel(reg_addr, supv_pkg::REG_STATE) ?
            {28'h0, masking, running} : 32'h0;

    // flags, reset request, pin float and interrupt
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            supervisor_event_flag_q <= 2'h0;
            irq_mask_q <= 2'h0;
            por_q <= 1'b0;
            float_q <= 1'b0;
            irq_q <= 1'b0;
            restart_q <= 1'b1;
            rdata_q <= 32'h0;
        end
        else
        begin
            supervisor_event_flag_q <= flag_d;
            if (reg_wr & sel(reg_addr, supv_pkg::REG_MASK))
                irq_mask_q <= reg_wdata[1:0];
            por_q <= |(hit & {ctrl_q[1][supv_pkg::CTRL_RESET_EN],
                              ctrl_q[0][supv_pkg::CTRL_RESET_EN]});
            float_q <= |(flag_d & masking) | (|hit);
            irq_q <= irq_d;
            restart_q <= soft_power_up_clear;
            rdata_q <= reg_rd ? rdata_d : 32'h0;
        end
    end

    assign reg_rdata = rdata_q;
    assign por_request = por_q;
    assign pins_float = float_q;
    assign irq = irq_q;

    a_flag_sets: assert property (@(posedge clk_sys) disable iff (rst)
        hit[0] |=> supervisor_event_flag_q[0])
        else $error("high flag not set by event");
    a_por_follows: assert property (@(posedge clk_sys) disable iff (rst)
        (hit[1] && ctrl_q[1][supv_pkg::CTRL_RESET_EN]) |=> por_request)
        else $error("reset not raised on low event");
    a_pins_float: assert property (@(posedge clk_sys) disable iff (rst)
        (|hit) |=> pins_float)
        else $error("pins not floated on event");
    a_clear_enables: assert property (@(posedge clk_sys) disable iff (rst)
        soft_power_up_clear |=> ctrl_q[0][0] && ctrl_q[1][0])
        else $error("clear did not enable supervisors");
    a_clear_masks: assert property (@(posedge clk_sys) disable iff (rst)
        soft_power_up_clear |=> ##1 masking == 2'h3)
        else $error("settling mask not restarted");

    // flag of the low side follows its own hit, apart from the high side
    a_low_flag_sets: assert property (@(posedge clk_sys) disable iff (rst)
        hit[1] |=> supervisor_event_flag_q[1])
        else $error("low flag not set by event");

    // reset request on the high side when its reset enable is set
    a_high_por: assert property (@(posedge clk_sys) disable iff (rst)
        (hit[0] && ctrl_q[0][supv_pkg::CTRL_RESET_EN]) |=> por_request)
        else $error("reset not raised on high event");

    // no reset request without a hit on a channel that allows it
    a_por_needs_hit: assert property (@(posedge clk_sys) disable iff (rst)
        !(hit[0] && ctrl_q[0][supv_pkg::CTRL_RESET_EN]) &&
        !(hit[1] && ctrl_q[1][supv_pkg::CTRL_RESET_EN]) |=>
        !por_request)
        else $error("reset raised without qualifying event");

    // a flag may only rise after a hit on its own channel
    a_high_rise_hit: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(supervisor_event_flag_q[0]) |-> $past(hit[0]))
        else $error("high flag rose without event");
    a_low_rise_hit: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(supervisor_event_flag_q[1]) |-> $past(hit[1]))
        else $error("low flag rose without event");

    // a masking channel cannot raise its flag, whatever the comparator does
    a_high_mask_flag: assert property (@(posedge clk_sys) disable iff (rst)
        (masking[0] && !supervisor_event_flag_q[0]) |=>
        !supervisor_event_flag_q[0])
        else $error("high flag set during settling mask");
    a_low_mask_flag: assert property (@(posedge clk_sys) disable iff (rst)
        (masking[1] && !supervisor_event_flag_q[1]) |=>
        !supervisor_event_flag_q[1])
        else $error("low flag set during settling mask");

    // with both channels masking, no reset can be requested either
    a_mask_no_por: assert property (@(posedge clk_sys) disable iff (rst)
        (masking == 2'h3) |=> !por_request)
        else $error("reset raised during settling mask");

    // one step: a status read, in a cycle with no new hit
    sequence s_quiet_status_read;
        status_rd && !(|hit);
    endsequence
    a_status_clears: assert property (@(posedge clk_sys) disable iff (rst)
        s_quiet_status_read |=> supervisor_event_flag_q == 2'h0)
        else $error("status read did not clear flags");

    // flags are sticky while nothing reads them
    a_flag_sticky: assert property (@(posedge clk_sys) disable iff (rst)
        (!status_rd && !(|hit)) |=> $stable(supervisor_event_flag_q))
        else $error("flag changed without event or read");

    // pins stay floating while a set flag waits for its channel to settle
    a_float_holds: assert property (@(posedge clk_sys) disable iff (rst)
        (|(flag_d & masking)) |=> pins_float)
        else $error("pins released before comparators settled");
    a_float_release: assert property (@(posedge clk_sys) disable iff (rst)
        (!(|(flag_d & masking)) && !(|hit)) |=> !pins_float)
        else $error("pins floated without cause");

    // interrupt level after one cycle of lag
    a_irq_raise: assert property (@(posedge clk_sys) disable iff (rst)
        irq_d |=> irq)
        else $error("interrupt not raised");
    a_irq_drop: assert property (@(posedge clk_sys) disable iff (rst)
        !irq_d |=> !irq)
        else $error("interrupt not dropped");

    // read data are zero in every cycle not following a read strobe
    a_rdata_idle: assert property (@(posedge clk_sys) disable iff (rst)
        !reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside read slot");

    // a status read returns the flags as they stood at the strobe
    a_rdata_status: assert property (@(posedge clk_sys) disable iff (rst)
        status_rd |=> reg_rdata[1:0] == $past(supervisor_event_flag_q))
        else $error("status read returned wrong flags");

    // mask writes land in one cycle
    a_mask_write: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_wr && sel(reg_addr, supv_pkg::REG_MASK)) |=>
        irq_mask_q == $past(reg_wdata[1:0]))
        else $error("mask write lost");

    // a soft clear schedules a restart of both settling masks
    a_clear_restart: assert property (@(posedge clk_sys) disable iff (rst)
        soft_power_up_clear |=> restart_q)
        else $error("restart not scheduled after clear");

    // in deep modes an unkept channel stops running
    a_high_deep_off: assert property (@(posedge clk_sys) disable iff (rst)
        (deep_low_power_modes && !ctrl_q[0][supv_pkg::CTRL_KEEP]) |=>
        !running[0])
        else $error("high side still running in deep mode");
    a_low_deep_off: assert property (@(posedge clk_sys) disable iff (rst)
        (deep_low_power_modes && !ctrl_q[1][supv_pkg::CTRL_KEEP]) |=>
        !running[1])
        else $error("low side still running in deep mode");
endmodule : supv_event_mask
`default_nettype wire

// ==== verif/supv_event_mask_tb_top.sv ====
// testbench for the supply supervisor event mask block
// assumes the package mask counts and one 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
module supv_event_mask_tb_top;
    // stimulus and observed outputs
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic soft_power_up_clear = 1'b0;
    logic deep_low_power_modes = 1'b0;
    logic [1:0] cmp_raw = 2'h0;
    logic por_request;
    logic pins_float;
    logic irq;
    int errors = 0;
    int n_tests = 0;
    int np;
    int nf;

    supv_event_mask i_dut (
        .clk_sys(clk_sys),
        .rst(rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .soft_power_up_clear(soft_power_up_clear),
        .deep_low_power_modes(deep_low_power_modes),
        .cmp_raw(cmp_raw),
        .por_request(por_request),
        .pins_float(pins_float),
        .irq(irq)
    );

    // free-running system clock
    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    // read data stand for one cycle only, so sample just after the edge
    task automatic rd(input logic [3:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata & m, e);
    endtask : rd

    // hold one trip for four cycles, count reset and float responses
    task automatic ev(input int i);
        np = 0;
        nf = 0;
        @(posedge clk_sys);
        cmp_raw[i] <= 1'b1;
        for (int k = 0; k < 9; k++)
        begin
            @(posedge clk_sys);
            if (k == 3)
                cmp_raw[i] <= 1'b0;
            #1;
            np += int'(por_request === 1'b1);
            nf += int'(pins_float === 1'b1);
        end
    endtask : ev

    task automatic end_of_test();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test

    // watchdog well beyond the two normal masks the tests sit through
    initial
    begin
        cyc(50000);
        errors++;
        end_of_test();
    end

    // main sequence
    initial
    begin
        cyc(12);
        rst <= 1'b0;
        rd(4'h0, 32'hffff, 32'h0303);
        rd(4'h7, 32'hffffffff, 32'h0);
        wr(4'h2, 32'h3);
        ev(0);
        chk(32'(np), 32'h0);
        rd(4'h1, 32'h3, 32'h0);
        cyc(supv_pkg::NORMAL_MASK_CYC);
        ev(0);
        chk(32'(np > 0), 32'h1);
        chk(32'(nf > 0), 32'h1);
        chk({31'h0, irq}, 32'h1);
        rd(4'h1, 32'h3, 32'h1);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        // high side fast, low side normal without reset
        wr(4'h0, 32'h0);
        wr(4'h0, 32'h010b);
        cyc(supv_pkg::FAST_MASK_CYC / 2);
        ev(0);
        chk(32'(np), 32'h0);
        cyc(supv_pkg::FAST_MASK_CYC);
        ev(0);
        chk(32'(np > 0), 32'h1);
        ev(1);
        rd(4'h1, 32'h3, 32'h1);
        cyc(supv_pkg::NORMAL_MASK_CYC);
        ev(1);
        chk(32'(np), 32'h0);
        rd(4'h1, 32'h3, 32'h2);
        // keep only the high side through deep mode
        wr(4'h0, 32'h0307);
        @(posedge clk_sys);
        deep_low_power_modes <= 1'b1;
        cyc(4);
        rd(4'h3, 32'h3, 32'h1);
        @(posedge clk_sys);
        deep_low_power_modes <= 1'b0;
        cyc(4);
        rd(4'h3, 32'hf, 32'hb);
        // soft clear with both supervisors off
        wr(4'h0, 32'h0);
        @(posedge clk_sys);
        soft_power_up_clear <= 1'b1;
        @(posedge clk_sys);
        soft_power_up_clear <= 1'b0;
        cyc(3);
        rd(4'h0, 32'h0101, 32'h0101);
        rd(4'h3, 32'hc, 32'hc);
        ev(0);
        chk(32'(np), 32'h0);
        rd(4'h1, 32'h3, 32'h0);
        end_of_test();
    end
endmodule : supv_event_mask_tb_top
`default_nettype wire
